// File: verilog/cit_core_timing.sv
`timescale 1ns/1ps
`include "cit_cfg.svh"

module cit_core_timing (
  // Clock and reset
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST_N,
  // Opcode from the fetch stage
  input  wire logic [`CIT_OP_W-1:0]  I_OPCODE,
  input  wire logic                  I_OPCODE_VALID,
  // Handshake and progress
  output logic                       O_READY,
  output logic                       O_BUSY,
  output logic                       O_DONE,
  output logic                       O_UNSUPPORTED,
  // Decoded size and timing
  output logic [`CIT_LEN_W-1:0]      O_LEN,
  output logic [`CIT_CYC_W-1:0]      O_CYCLES,
  output cit_pkg::cit_class_type     O_CLASS
);
  import cit_pkg::*;

  // Map an opcode to its timing class
  function automatic cit_class_type decode_op(input logic [`CIT_OP_W-1:0] op);
    cit_class_type c;
    c = CIT_CLS_NONE;
    if (op[`CIT_RN_BIT]) begin
      // Working register column
      unique case (op[`CIT_HI_MSB:`CIT_HI_LSB])
        4'h0: c = CIT_CLS_REG;                      // Increment register
        4'h1: c = CIT_CLS_REG;                      // Decrement register
        4'h2: c = CIT_CLS_REG;                      // Add register
        4'h3: c = CIT_CLS_REG;
        4'h4: c = CIT_CLS_REG;                      // OR register
        4'h5: c = CIT_CLS_REG;                      // AND register
        4'h6: c = CIT_CLS_REG;                      // Exclusive-OR register
        4'h7: c = CIT_CLS_IMM;                      // Immediate to register
        4'h8: c = CIT_CLS_DIR;                      // Register to direct
        4'h9: c = CIT_CLS_REG;
        4'hA: c = CIT_CLS_DIR;                      // Direct to register
        4'hB: c = CIT_CLS_NONE;                     // Compare-and-branch, timed elsewhere
        4'hC: c = CIT_CLS_REG;                      // Exchange with register
        4'hD: c = CIT_CLS_NONE;                     // Loop branch, timed elsewhere
        4'hE: c = CIT_CLS_REG;                      // Register to accumulator
        4'hF: c = CIT_CLS_REG;                      // Accumulator to register
      endcase
    end else if (op[`CIT_RI_MSB:`CIT_RI_LSB] == `CIT_RI_COL) begin
      // Register-held indirect pointer column
      unique case (op[`CIT_HI_MSB:`CIT_HI_LSB])
        4'h0: c = CIT_CLS_IND;
        4'h1: c = CIT_CLS_IND;
        4'h2: c = CIT_CLS_IND;
        4'h3: c = CIT_CLS_IND;
        4'h4: c = CIT_CLS_IND;                      // OR indirect
        4'h5: c = CIT_CLS_IND;                      // AND indirect
        4'h6: c = CIT_CLS_IND;                      // One byte by encoding, printed size not used
        4'h7: c = CIT_CLS_IMM;
        4'h8: c = CIT_CLS_DIR;                      // Indirect to direct
        4'h9: c = CIT_CLS_IND;
        4'hA: c = CIT_CLS_DIR;                      // Direct to indirect
        4'hB: c = CIT_CLS_NONE;                     // Compare-and-branch, timed elsewhere
        4'hC: c = CIT_CLS_IND;                      // Exchange with indirect byte
        4'hD: c = CIT_CLS_IND;
        4'hE: c = CIT_CLS_IND;                      // Indirect to accumulator
        4'hF: c = CIT_CLS_IND;
      endcase
    end else begin
      // Remaining columns 0 to 5 hold the mixed forms
      case (op)
        8'h00: c = CIT_CLS_NONE;                    // No-op row not covered here
        8'h03: c = CIT_CLS_ACC;
        8'h04: c = CIT_CLS_ACC;                     // Increment accumulator
        8'h13: c = CIT_CLS_ACC;
        8'h14: c = CIT_CLS_ACC;                     // Decrement accumulator
        8'h15: c = CIT_CLS_DIR;                     // Decrement direct byte
        8'h23: c = CIT_CLS_ACC;
        8'h24: c = CIT_CLS_IMM;
        8'h25: c = CIT_CLS_DIR;
        8'h33: c = CIT_CLS_ACC;
        8'h34: c = CIT_CLS_IMM;
        8'h35: c = CIT_CLS_DIR;
        8'h42: c = CIT_CLS_DIR;
        8'h43: c = CIT_CLS_DIR_IMM;
        8'h44: c = CIT_CLS_IMM;                     // OR immediate
        8'h45: c = CIT_CLS_DIR;                     // OR direct
        8'h52: c = CIT_CLS_DIR;
        8'h53: c = CIT_CLS_DIR_IMM;
        8'h54: c = CIT_CLS_IMM;                     // AND immediate
        8'h55: c = CIT_CLS_DIR;                     // AND direct
        8'h62: c = CIT_CLS_DIR;
        8'h63: c = CIT_CLS_DIR_IMM;
        8'h64: c = CIT_CLS_IMM;                     // Exclusive-OR immediate
        8'h65: c = CIT_CLS_DIR;                     // Exclusive-OR direct
        8'h72: c = CIT_CLS_BIT;
        8'h74: c = CIT_CLS_IMM;                     // Immediate to accumulator
        8'h75: c = CIT_CLS_DIR_IMM;                 // Immediate to direct
        8'h82: c = CIT_CLS_BIT;
        8'h83: c = CIT_CLS_CODE;
        8'h85: c = CIT_CLS_DIR_DIR;
        8'h90: c = CIT_CLS_DATA_POINTER_REGISTER_IMM;
        8'h92: c = CIT_CLS_BIT;
        8'h93: c = CIT_CLS_CODE;
        8'h94: c = CIT_CLS_IMM;
        8'h95: c = CIT_CLS_DIR;
        8'hA0: c = CIT_CLS_BIT;
        8'hA2: c = CIT_CLS_BIT;                     // Direct bit to carry
        8'hA3: c = CIT_CLS_DATA_POINTER_REGISTER_INC;                // Pointer increment
        8'hB0: c = CIT_CLS_BIT;
        8'hB2: c = CIT_CLS_BIT;                     // Complement direct bit
        8'hB3: c = CIT_CLS_ACC;                     // Complement carry
        8'hC0: c = CIT_CLS_STACK;
        8'hC3: c = CIT_CLS_ACC;                     // Clear carry
        8'hC4: c = CIT_CLS_ACC;
        8'hC5: c = CIT_CLS_DIR;                     // Exchange with direct byte
        8'hD0: c = CIT_CLS_STACK;
        8'hD3: c = CIT_CLS_ACC;                     // Set carry
        8'hD4: c = CIT_CLS_ADJ;                     // Decimal adjust
        8'hE0: c = CIT_CLS_XMEM;
        8'hE2: c = CIT_CLS_XMEM;
        8'hE3: c = CIT_CLS_XMEM;
        8'hE4: c = CIT_CLS_ACC;
        8'hE5: c = CIT_CLS_DIR;                     // Direct to accumulator
        8'hF0: c = CIT_CLS_XMEM;
        8'hF2: c = CIT_CLS_XMEM;
        8'hF3: c = CIT_CLS_XMEM;
        8'hF4: c = CIT_CLS_ACC;
        8'hF5: c = CIT_CLS_DIR;                     // Accumulator to direct
        // Branches, calls, multiply, divide and unclear rows stay out
        default: c = CIT_CLS_NONE;
      endcase
    end
    return c;
  endfunction

  // Encoded size of each class
  function automatic logic [`CIT_LEN_W-1:0] class_len(input cit_class_type c);
    logic [`CIT_LEN_W-1:0] n;
    n = `CIT_LEN_NONE;
    unique case (c)
      CIT_CLS_NONE:     n = `CIT_LEN_NONE;
      CIT_CLS_REG:      n = `CIT_LEN_1;
      CIT_CLS_ACC:      n = `CIT_LEN_1;
      CIT_CLS_IND:      n = `CIT_LEN_1;
      CIT_CLS_ADJ:      n = `CIT_LEN_1;
      CIT_CLS_DIR:      n = `CIT_LEN_2;
      CIT_CLS_IMM:      n = `CIT_LEN_2;
      CIT_CLS_BIT:      n = `CIT_LEN_2;
      CIT_CLS_STACK:    n = `CIT_LEN_2;
      CIT_CLS_DIR_IMM:  n = `CIT_LEN_3;
      CIT_CLS_DIR_DIR:  n = `CIT_LEN_3;
      CIT_CLS_DATA_POINTER_REGISTER_IMM: n = `CIT_LEN_3;
      CIT_CLS_DATA_POINTER_REGISTER_INC: n = `CIT_LEN_1;
      CIT_CLS_CODE:     n = `CIT_LEN_1;
      CIT_CLS_XMEM:     n = `CIT_LEN_1;
    endcase
    return n;
  endfunction

  // Core clock cycles of each class
  function automatic logic [`CIT_CYC_W-1:0] class_cycles(input cit_class_type c);
    logic [`CIT_CYC_W-1:0] n;
    n = `CIT_CYC_NONE;
    unique case (c)
      CIT_CLS_NONE:     n = `CIT_CYC_NONE;
      CIT_CLS_REG:      n = `CIT_CYC_1;
      CIT_CLS_ACC:      n = `CIT_CYC_1;
      CIT_CLS_IND:      n = `CIT_CYC_2;
      CIT_CLS_ADJ:      n = `CIT_CYC_2;
      CIT_CLS_DIR:      n = `CIT_CYC_2;
      CIT_CLS_IMM:      n = `CIT_CYC_2;
      CIT_CLS_BIT:      n = `CIT_CYC_2;
      CIT_CLS_STACK:    n = `CIT_CYC_2;
      CIT_CLS_DIR_IMM:  n = `CIT_CYC_3;
      CIT_CLS_DIR_DIR:  n = `CIT_CYC_3;
      CIT_CLS_DATA_POINTER_REGISTER_IMM: n = `CIT_CYC_3;
      CIT_CLS_DATA_POINTER_REGISTER_INC: n = `CIT_CYC_3;
      CIT_CLS_CODE:     n = `CIT_CYC_4;
      CIT_CLS_XMEM:     n = `CIT_CYC_4;
    endcase
    return n;
  endfunction

  cit_dec_type           st_q;
  cit_dec_type           st_d;
  cit_class_type         op_cls;
  logic                  accept;
  logic                  load;
  logic                  tmr_busy;
  logic                  tmr_done;
  logic                  tmr_ready;

  // Opcode is taken only while the timer says the core can start
  assign op_cls = decode_op(I_OPCODE);
  assign accept = I_OPCODE_VALID && tmr_ready;
  assign load   = accept && (op_cls != CIT_CLS_NONE);

  // Hold the result of the last accepted opcode; unsupported ones pulse a flag
  always_comb begin
    st_d             = st_q;
    st_d.unsupported = 1'h0;
    if (accept) begin
      st_d.cls         = op_cls;
      st_d.len         = class_len(op_cls);
      st_d.cycles      = class_cycles(op_cls);
      st_d.unsupported = (op_cls == CIT_CLS_NONE);
    end
  end

  // State register
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st_q.len         <= `CIT_LEN_NONE;
      st_q.cycles      <= `CIT_CYC_NONE;
      st_q.cls         <= CIT_CLS_NONE;
      st_q.unsupported <= `CIT_FLAG_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Cycle sequencing; its outputs are flip-flops inside the timer
  cit_cycle_timer u_timer (
    .i_clk    (I_CLK),
    .i_rst_n  (I_RST_N),
    .i_load   (load),
    .i_cycles (class_cycles(op_cls)),
    .o_busy   (tmr_busy),
    .o_done   (tmr_done),
    .o_ready  (tmr_ready)
  );

  // Outputs
  assign O_READY       = tmr_ready;
  assign O_BUSY        = tmr_busy;
  assign O_DONE        = tmr_done;
  assign O_UNSUPPORTED = st_q.unsupported;
  assign O_LEN         = st_q.len;
  assign O_CYCLES      = st_q.cycles;
  assign O_CLASS       = st_q.cls;

endmodule

// File: pkg/cit_cfg.svh
`ifndef CIT_CFG_SVH
`define CIT_CFG_SVH

// Widths
`define CIT_OP_W      8
`define CIT_LEN_W     2
`define CIT_CYC_W     3

// Opcode field positions
`define CIT_RN_BIT    3
`define CIT_RI_MSB    3
`define CIT_RI_LSB    1
`define CIT_RI_COL    3'h3
`define CIT_HI_MSB    7
`define CIT_HI_LSB    4

// Encoded sizes in bytes
`define CIT_LEN_NONE  2'h0
`define CIT_LEN_1     2'h1
`define CIT_LEN_2     2'h2
`define CIT_LEN_3     2'h3

// Core clock cycles per instruction
`define CIT_CYC_NONE  3'h0
`define CIT_CYC_1     3'h1
`define CIT_CYC_2     3'h2
`define CIT_CYC_3     3'h3
`define CIT_CYC_4     3'h4

// Reset values
`define CIT_READY_RST 1'h1
`define CIT_FLAG_RST  1'h0
`define CIT_CNT_RST   3'h0

`endif

// File: pkg/cit_pkg.sv
`include "cit_cfg.svh"

package cit_pkg;

  // Timing class of a decoded opcode
  typedef enum logic [3:0] {
    CIT_CLS_NONE,
    CIT_CLS_REG,
    CIT_CLS_ACC,
    CIT_CLS_IND,
    CIT_CLS_ADJ,
    CIT_CLS_DIR,
    CIT_CLS_IMM,
    CIT_CLS_BIT,
    CIT_CLS_STACK,
    CIT_CLS_DIR_IMM,
    CIT_CLS_DIR_DIR,
    CIT_CLS_DATA_POINTER_REGISTER_IMM,
    CIT_CLS_DATA_POINTER_REGISTER_INC,
    CIT_CLS_CODE,
    CIT_CLS_XMEM
  } cit_class_type;

  // Cycle timer state
  typedef struct packed {
    logic                  busy;
    logic                  done;
    logic                  ready;
    logic [`CIT_CYC_W-1:0] remaining;
  } cit_timer_type;

  // Decoder state
  typedef struct packed {
    logic [`CIT_LEN_W-1:0] len;
    logic [`CIT_CYC_W-1:0] cycles;
    cit_class_type         cls;
    logic                  unsupported;
  } cit_dec_type;

endpackage

// File: verilog/cit_cycle_timer.sv
`timescale 1ns/1ps
`include "cit_cfg.svh"

module cit_cycle_timer (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // Load of a new instruction
  input  wire logic                  i_load,
  input  wire logic [`CIT_CYC_W-1:0] i_cycles,
  // Timing state
  output logic                       o_busy,
  output logic                       o_done,
  output logic                       o_ready
);
  import cit_pkg::*;

  cit_timer_type st_q;
  cit_timer_type st_d;

  // Count down the cycles of the running instruction
  always_comb begin
    st_d = st_q;
    if (i_load) begin
      // Ready again in the last cycle so instructions can run back to back
      st_d.busy      = 1'h1;
      st_d.remaining = i_cycles - `CIT_CYC_1;
      st_d.done      = (i_cycles == `CIT_CYC_1);
      st_d.ready     = (i_cycles == `CIT_CYC_1);
    end else if (st_q.busy) begin
      if (st_q.done) begin
        st_d.busy  = 1'h0;
        st_d.done  = 1'h0;
        st_d.ready = 1'h1;
      end else begin
        st_d.remaining = st_q.remaining - `CIT_CYC_1;
        st_d.done      = (st_q.remaining == `CIT_CYC_1);
        st_d.ready     = (st_q.remaining == `CIT_CYC_1);
      end
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_q.busy      <= `CIT_FLAG_RST;
      st_q.done      <= `CIT_FLAG_RST;
      st_q.ready     <= `CIT_READY_RST;
      st_q.remaining <= `CIT_CNT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_busy  = st_q.busy;
  assign o_done  = st_q.done;
  assign o_ready = st_q.ready;

endmodule

// File: verification/cit_core_timing_asserts.sv
`timescale 1ns/1ps
`include "cit_cfg.svh"

module cit_core_timing_chk (
  // Clock and reset
  input wire logic                  I_CLK,
  input wire logic                  I_RST_N,
  // Opcode request
  input wire logic [`CIT_OP_W-1:0]  I_OPCODE,
  input wire logic                  I_OPCODE_VALID,
  // Progress and decoded values
  input wire logic                  O_READY,
  input wire logic                  O_BUSY,
  input wire logic                  O_DONE,
  input wire logic                  O_UNSUPPORTED,
  input wire logic [`CIT_LEN_W-1:0] O_LEN,
  input wire logic [`CIT_CYC_W-1:0] O_CYCLES,
  input wire cit_pkg::cit_class_type O_CLASS
);
  import cit_pkg::*;

  logic taken;

  // An opcode counts only at an edge where both sides agree
  assign taken = I_OPCODE_VALID && O_READY;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  property p_reg_arith;
    taken && (I_OPCODE[7:4] inside {4'h3, 4'h9}) && I_OPCODE[3] |=> O_DONE && O_LEN == 2'h1 && O_CYCLES == 3'h1;
  endproperty
  property p_ind_arith;
    taken && (I_OPCODE inside {8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97}) |=> O_LEN == 2'h1 && !O_DONE ##1 O_DONE;
  endproperty
  property p_imm_logic;
    taken && (I_OPCODE inside {8'h53, 8'h43}) |=> O_LEN == 2'h3 && !O_READY ##1 !O_DONE ##1 O_DONE;
  endproperty
  property p_xor_dir_imm;
    taken && I_OPCODE == 8'h63 |=> O_CYCLES == 3'h3 ##2 (O_DONE && O_READY);
  endproperty
  property p_acc_only;
    taken && (I_OPCODE inside {8'hE4, 8'hF4, 8'hC4, 8'h23, 8'h33, 8'h03, 8'h13}) |=> O_DONE && O_READY && O_LEN == 2'h1;
  endproperty
  // Ready must stay low for the whole wait, not only at its end
  property p_code_load;
    taken && (I_OPCODE inside {8'h93, 8'h83}) |=> (O_BUSY && !O_READY)[*3] ##1 (O_DONE && O_LEN == 2'h1);
  endproperty
  property p_xmem;
    taken && ((I_OPCODE & 8'hEC) == 8'hE0) && I_OPCODE[1:0] != 2'h1 |=> O_CYCLES == 3'h4 && O_LEN == 2'h1 ##3 O_DONE;
  endproperty
  property p_data_pointer_register_load;
    taken && I_OPCODE == 8'h90 |=> O_LEN == 2'h3 && O_CYCLES == 3'h3 && !O_DONE ##1 !O_DONE ##1 O_DONE;
  endproperty
  property p_dir_dir;
    taken && I_OPCODE == 8'h85 |=> (!O_DONE)[*2] ##1 O_DONE;
  endproperty
  property p_carry_bit;
    taken && (I_OPCODE inside {8'h82, 8'hB0, 8'h72, 8'hA0, 8'h92}) |=> O_LEN == 2'h2 && !O_DONE ##1 O_DONE;
  endproperty

  a_reg_arith: assert property (p_reg_arith)
    else $error("register arithmetic timing wrong");
  a_ind_arith: assert property (p_ind_arith)
    else $error("indirect arithmetic timing wrong");
  a_imm_logic: assert property (p_imm_logic)
    else $error("and or immediate to direct timing wrong");
  a_xor_dir_imm: assert property (p_xor_dir_imm)
    else $error("xor immediate to direct timing wrong");
  a_acc_only: assert property (p_acc_only)
    else $error("accumulator operation timing wrong");
  a_code_load: assert property (p_code_load)
    else $error("code byte load timing wrong");
  a_xmem: assert property (p_xmem)
    else $error("extended move timing wrong");
  a_data_pointer_register_load: assert property (p_data_pointer_register_load)
    else $error("pointer load size wrong");
  a_dir_dir: assert property (p_dir_dir)
    else $error("direct to direct timing wrong");
  a_carry_bit: assert property (p_carry_bit)
    else $error("carry bit operation timing wrong");

  // Main scenarios reached
  c_xmem_done: cover property (O_DONE && O_CLASS == CIT_CLS_XMEM);
  c_back_to_back: cover property (O_DONE && I_OPCODE_VALID);
  c_unsupported: cover property (O_UNSUPPORTED);
endmodule

bind cit_core_timing cit_core_timing_chk u_chk (
  .I_CLK          (I_CLK),
  .I_RST_N        (I_RST_N),
  .I_OPCODE       (I_OPCODE),
  .I_OPCODE_VALID (I_OPCODE_VALID),
  .O_READY        (O_READY),
  .O_BUSY         (O_BUSY),
  .O_DONE         (O_DONE),
  .O_UNSUPPORTED  (O_UNSUPPORTED),
  .O_LEN          (O_LEN),
  .O_CYCLES       (O_CYCLES),
  .O_CLASS        (O_CLASS)
);

// File: verification/tb.sv
`timescale 1ns/1ps
`include "cit_cfg.svh"

module tb;
  import cit_pkg::*;
  logic                  clk;
  logic                  rst_n;
  logic [`CIT_OP_W-1:0]  opcode;
  logic                  opcode_valid;
  logic                  ready;
  logic                  busy;
  logic                  done;
  logic                  unsup;
  logic [`CIT_LEN_W-1:0] len;
  logic [`CIT_CYC_W-1:0] cyc;
  cit_class_type         cls;
  int                    n_errors;
  int                    check_count;

  cit_core_timing uut (
    .I_CLK          (clk),
    .I_RST_N        (rst_n),
    .I_OPCODE       (opcode),
    .I_OPCODE_VALID (opcode_valid),
    .O_READY        (ready),
    .O_BUSY         (busy),
    .O_DONE         (done),
    .O_UNSUPPORTED  (unsup),
    .O_LEN          (len),
    .O_CYCLES       (cyc),
    .O_CLASS        (cls)
  );

  // 250 MHz core clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // One comparison, reported at once on mismatch
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Issue one opcode and follow it to the end; ecyc of 0 means refused as unsupported
  task automatic run_op(input logic [7:0] op, input logic [1:0] elen, input logic [2:0] ecyc);
    int k;
    @(negedge clk);
    opcode       = op;
    opcode_valid = 1'h1;
    @(negedge clk);
    opcode_valid = 1'h0;
    chk(8'(unsup), (ecyc == 3'h0) ? 8'h01 : 8'h00);
    for (k = 1; k <= ecyc; k++) begin
      if (k > 1) @(negedge clk);
      chk(8'(busy), 8'h01);
      chk(8'(done), (k == ecyc) ? 8'h01 : 8'h00);
      chk(8'(ready), (k == ecyc) ? 8'h01 : 8'h00);
    end
    chk(8'(len), 8'(elen));
    chk(8'(cyc), 8'(ecyc));
    @(negedge clk);
    chk(8'(busy), 8'h00);
  endtask

  task automatic t_arith();
    run_op(8'h38, 2'h1, 3'h1);
    run_op(8'h9F, 2'h1, 3'h1);
    run_op(8'h26, 2'h1, 3'h2);
    run_op(8'h97, 2'h1, 3'h2);
    run_op(8'h25, 2'h2, 3'h2);
    run_op(8'h94, 2'h2, 3'h2);
    run_op(8'hA3, 2'h1, 3'h3);
    run_op(8'hD4, 2'h1, 3'h2);
    $display("test arith done");
  endtask

  task automatic t_logic();
    logic [7:0] acc_ops[7];
    acc_ops = '{8'hE4, 8'hF4, 8'hC4, 8'h23, 8'h33, 8'h03, 8'h13};
    run_op(8'h53, 2'h3, 3'h3);
    run_op(8'h43, 2'h3, 3'h3);
    run_op(8'h63, 2'h3, 3'h3);
    run_op(8'h52, 2'h2, 3'h2);
    run_op(8'h42, 2'h2, 3'h2);
    run_op(8'h62, 2'h2, 3'h2);
    foreach (acc_ops[i]) run_op(acc_ops[i], 2'h1, 3'h1);
    $display("test logic done");
  endtask

  task automatic t_transfer();
    logic [7:0] xm_ops[6];
    xm_ops = '{8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
    run_op(8'h93, 2'h1, 3'h4);
    chk(8'(cls), 8'(CIT_CLS_CODE));
    run_op(8'h83, 2'h1, 3'h4);
    foreach (xm_ops[i]) run_op(xm_ops[i], 2'h1, 3'h4);
    chk(8'(cls), 8'(CIT_CLS_XMEM));
    run_op(8'h90, 2'h3, 3'h3);
    run_op(8'h85, 2'h3, 3'h3);
    run_op(8'hF7, 2'h1, 3'h2);
    run_op(8'h76, 2'h2, 3'h2);
    run_op(8'hD6, 2'h1, 3'h2);
    $display("test transfer done");
  endtask

  task automatic t_stack_bits();
    run_op(8'hC0, 2'h2, 3'h2);
    run_op(8'hD0, 2'h2, 3'h2);
    run_op(8'h82, 2'h2, 3'h2);
    run_op(8'hB0, 2'h2, 3'h2);
    run_op(8'h72, 2'h2, 3'h2);
    run_op(8'hA0, 2'h2, 3'h2);
    run_op(8'h92, 2'h2, 3'h2);
    $display("test stack and bits done");
  endtask

  // Outside the covered set: size and timing read zero, nothing runs
  task automatic t_unsupported();
    run_op(8'h00, 2'h0, 3'h0);
    run_op(8'hA4, 2'h0, 3'h0);
    chk(8'(cls), 8'(CIT_CLS_NONE));
    $display("test unsupported done");
  endtask

  // Second opcode waits through the refused cycles, then is taken on the done cycle
  task automatic t_back_to_back();
    int k;
    @(negedge clk);
    opcode       = 8'hE0;
    opcode_valid = 1'h1;
    @(negedge clk);
    opcode = 8'h24;
    for (k = 1; k <= 4; k++) begin
      if (k > 1) @(negedge clk);
      chk(8'(cyc), 8'h04);
      chk(8'(ready), (k == 4) ? 8'h01 : 8'h00);
    end
    chk(8'(done), 8'h01);
    @(negedge clk);
    opcode_valid = 1'h0;
    chk(8'(busy), 8'h01);
    chk(8'(len), 8'h02);
    chk(8'(done), 8'h00);
    @(negedge clk);
    chk(8'(done), 8'h01);
    $display("test back to back done");
  endtask

  // Reset during an extended move drops it; the next opcode runs normally
  task automatic t_reset_mid();
    @(negedge clk);
    opcode       = 8'hE2;
    opcode_valid = 1'h1;
    @(negedge clk);
    opcode_valid = 1'h0;
    rst_n        = 1'h0;
    @(negedge clk);
    chk(8'(busy), 8'h00);
    chk(8'(ready), 8'h01);
    chk(8'(done), 8'h00);
    chk(8'(cyc), 8'h00);
    rst_n = 1'h1;
    run_op(8'hE4, 2'h1, 3'h1);
    $display("test reset mid done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence: reset, reset values, then the scenarios
  initial begin
    n_errors     = 0;
    check_count  = 0;
    rst_n        = 1'h0;
    opcode       = 8'h00;
    opcode_valid = 1'h0;
    repeat (20) @(negedge clk);
    chk(8'(ready), 8'h01);
    chk(8'(busy), 8'h00);
    chk(8'(len), 8'h00);
    rst_n = 1'h1;
    t_arith();
    t_logic();
    t_transfer();
    t_stack_bits();
    t_unsupported();
    t_back_to_back();
    t_reset_mid();
    print_verdict();
  end

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule
